// [nvac_pkg.sv]
package nvac_pkg;
  // register indices on the io port
  localparam logic [1:0] NVAC_REG_ADDR_LOWER = 2'h0;
  localparam logic [1:0] NVAC_REG_ADDR_UPPER = 2'h1;
  localparam logic [1:0] NVAC_REG_BUFFER = 2'h2;
  localparam logic [1:0] NVAC_REG_CONTROL = 2'h3;
  // control register fields
  localparam int NVAC_BIT_READ = 0;
  localparam int NVAC_BIT_START = 1;
  localparam int NVAC_BIT_ARM = 2;
  localparam int NVAC_BIT_RDY_EN = 3;
  localparam int NVAC_BIT_MODE_LO = 4;
  localparam int NVAC_BIT_MODE_HI = 5;
  // mode encodings
  localparam logic [1:0] NVAC_MODE_ATOMIC = 2'h0;
  localparam logic [1:0] NVAC_MODE_ERASE = 2'h1;
  localparam logic [1:0] NVAC_MODE_WRITE = 2'h2;
  localparam logic [1:0] NVAC_MODE_RSVD = 2'h3;
  // reset values
  localparam logic [7:0] NVAC_BUFFER_RST = 8'h00;
  localparam logic [1:0] NVAC_MODE_RST = 2'h0;
  // timing
  localparam int NVAC_ARM_CYCLES = 4;
  localparam int NVAC_READ_STALL = 4;
  localparam int NVAC_PROG_STALL = 2;
  localparam int NVAC_ATOMIC_US = 3400;
  localparam int NVAC_SPLIT_US = 1800;
  localparam int NVAC_OSC_KHZ = 8000;
  localparam int NVAC_ATOMIC_TICKS = NVAC_ATOMIC_US * NVAC_OSC_KHZ / 1000;
  localparam int NVAC_SPLIT_TICKS = NVAC_SPLIT_US * NVAC_OSC_KHZ / 1000;
  localparam int NVAC_TIMER_W = 16;
  localparam int NVAC_ADDR_W = 9;
  typedef enum logic [2:0] {
    NVAC_IDLE = 3'b001,
    NVAC_ERASE = 3'b010,
    NVAC_WRITE = 3'b100
  } nvac_state_t;
endpackage : nvac_pkg

// [nvac_prog_timer.sv]
`timescale 1ns/100ps
// counts calibrated oscillator ticks, runs on mclk
module nvac_prog_timer
  import nvac_pkg::*;
#(
  parameter int W = NVAC_TIMER_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic osc_tick,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic run_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      run_r <= 1'b1;
    end else if (run_r) begin
      if (osc_tick) begin
        if (cnt_r <= W'(1))
          run_r <= 1'b0;
        cnt_r <= cnt_r - W'(1);
      end
    end else begin
      // unknown run flag at power-up falls to idle
      run_r <= 1'b0;
    end
  end

  assign done = run_r && osc_tick && (cnt_r <= W'(1));
endmodule : nvac_prog_timer

// [nvac_ctrl.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - a read trigger stalls the cpu four clock cycles
// - a program start stalls the cpu two clock cycles
// - mode 00 armed start does erase then write of addressed byte
// - start bit stays set until the whole operation ends
// - while programming, no other operation is accepted
// - mode 01 armed start erases only, start held until done
// - mode 10 armed start writes only, start held until done
// - durations timed by calibrated oscillator ticks
// - reset does not abort a running program operation
// - nine bit address over two registers, upper 7:1 read zero
// - arm bit self clears four cycles after set
// - mode writes ignored while busy, 11 reserved, reset clears only while idle
// - read gives data at once, blocked with address during write
// - 3.4ms atomic, 1.8ms erase or write only
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int ATOMIC_TICKS = NVAC_ATOMIC_TICKS,
  parameter int SPLIT_TICKS = NVAC_SPLIT_TICKS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic osc_tick,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic ready_event,
  output logic [NVAC_ADDR_W-1:0] nv_index,
  output logic [7:0] nv_wdata,
  output logic nv_erase,
  output logic nv_write,
  input wire logic [7:0] nv_rdata
);
  logic [NVAC_ADDR_W-1:0] index_r, index_nxt;
  logic [7:0] buf_r, rdata_r;
  logic [1:0] mode_r;
  logic arm_r, busy_r, rdy_en_r, rdy_r, stall_r, erase_r, write_r;
  logic [2:0] arm_cnt_r, stall_cnt_r;
  nvac_state_t state_r;
  logic wr_ctl, go, rd_go, done;
  logic [NVAC_TIMER_W-1:0] ticks;
  // reset of cpu side only; programming engine keeps running
  logic hold_rst;

  assign wr_ctl = io_wr && io_addr == NVAC_REG_CONTROL;
  assign go = wr_ctl && io_wdata[NVAC_BIT_START] && arm_r && !busy_r
    && mode_r != NVAC_MODE_RSVD;
  assign rd_go = wr_ctl && io_wdata[NVAC_BIT_READ] && !busy_r;
  assign ticks = (mode_r == NVAC_MODE_ATOMIC)
    ? NVAC_TIMER_W'(ATOMIC_TICKS) : NVAC_TIMER_W'(SPLIT_TICKS);
  assign hold_rst = 1'b1;

  nvac_prog_timer #(.W(NVAC_TIMER_W)) u_timer (
    .mclk(mclk),
    .nrst(hold_rst),
    .osc_tick(osc_tick),
    .load(go),
    .count(ticks),
    .done(done)
  );

  ////////////////////////////////////////////////////////////////////////
  // programming engine, not reset so an operation completes
  // unknown state at power-up falls to idle through the default branch
  always_ff @(posedge mclk) begin
    case (state_r)
      NVAC_IDLE: begin
        // array index follows the address register while idle
        nv_index <= index_nxt;
        if (go) begin
          busy_r <= 1'b1;
          nv_wdata <= buf_r;
          if (mode_r == NVAC_MODE_WRITE)
            state_r <= NVAC_WRITE;
          else
            state_r <= NVAC_ERASE;
        end else begin
          busy_r <= 1'b0;
        end
      end
      NVAC_ERASE, NVAC_WRITE: begin
        if (done) begin
          busy_r <= 1'b0;
          state_r <= NVAC_IDLE;
        end
      end
      default: begin
        busy_r <= 1'b0;
        state_r <= NVAC_IDLE;
      end
    endcase
  end

  // erase/write strobes to array, not reset so a cut operation still ends
  always_ff @(posedge mclk) begin
    erase_r <= go && mode_r != NVAC_MODE_WRITE;
    write_r <= done && mode_r != NVAC_MODE_ERASE;
  end
  assign nv_erase = erase_r;
  assign nv_write = write_r;

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_comb begin
    index_nxt = index_r;
    if (io_wr && !busy_r && io_addr == NVAC_REG_ADDR_LOWER)
      index_nxt[7:0] = io_wdata;
    if (io_wr && !busy_r && io_addr == NVAC_REG_ADDR_UPPER)
      index_nxt[8] = io_wdata[0];
  end

  always_ff @(posedge mclk) begin
    index_r <= index_nxt;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      buf_r <= NVAC_BUFFER_RST;
    else if (rd_go)
      buf_r <= nv_rdata;
    else if (io_wr && io_addr == NVAC_REG_BUFFER)
      buf_r <= io_wdata;
  end

  // mode survives a reset that lands while programming
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      if (!busy_r)
        mode_r <= NVAC_MODE_RST;
    end else if (wr_ctl && !busy_r) begin
      mode_r <= io_wdata[NVAC_BIT_MODE_HI:NVAC_BIT_MODE_LO];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdy_en_r <= 1'b0;
    else if (wr_ctl)
      rdy_en_r <= io_wdata[NVAC_BIT_RDY_EN];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (wr_ctl && io_wdata[NVAC_BIT_ARM]) begin
      arm_r <= 1'b1;
      arm_cnt_r <= 3'(NVAC_ARM_CYCLES);
    end else if (arm_r) begin
      arm_cnt_r <= arm_cnt_r - 3'h1;
      if (arm_cnt_r == 3'h1 || go)
        arm_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stall_cnt_r <= 3'h0;
      stall_r <= 1'b0;
    end else if (rd_go) begin
      stall_cnt_r <= 3'(NVAC_READ_STALL - 1);
      stall_r <= 1'b1;
    end else if (go) begin
      stall_cnt_r <= 3'(NVAC_PROG_STALL - 1);
      stall_r <= 1'b1;
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end else begin
      stall_r <= 1'b0;
    end
  end
  assign cpu_stall = stall_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdy_r <= 1'b0;
    else
      rdy_r <= rdy_en_r && !busy_r && !go;
  end
  assign ready_event = rdy_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (io_rd)
      case (io_addr)
        NVAC_REG_ADDR_LOWER: rdata_r <= index_r[7:0];
        NVAC_REG_ADDR_UPPER: rdata_r <= {7'h00, index_r[8]};
        NVAC_REG_BUFFER: rdata_r <= buf_r;
        NVAC_REG_CONTROL: rdata_r <= {2'h0, mode_r, rdy_en_r, arm_r,
          busy_r, 1'b0};
        default: rdata_r <= 8'h00;
      endcase
  end
  assign io_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  chk_stall_after_read: assert property (@(posedge mclk) disable iff (!nrst)
    rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  chk_stall_after_prog: assert property (@(posedge mclk) disable iff (!nrst)
    go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall not two cycles");
  chk_start_busy: assert property (@(posedge mclk) disable iff (!nrst)
    go |=> busy_r)
    else $error("busy not set after start");
  chk_no_go_busy: assert property (@(posedge mclk) disable iff (!nrst)
    busy_r |-> !go && !rd_go && (!$past(busy_r) || !nv_erase
    && $stable(nv_index)))
    else $error("operation accepted while busy");
  chk_arm_clear: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_ctl && io_wdata[NVAC_BIT_ARM]) ##1 !wr_ctl [*4] |=> !arm_r)
    else $error("arm not cleared after four cycles");
  chk_mode_hold: assert property (@(posedge mclk) disable iff (!nrst)
    busy_r && !done |=> $stable(mode_r))
    else $error("mode changed while busy");
  chk_read_data: assert property (@(posedge mclk) disable iff (!nrst)
    rd_go |=> buf_r == $past(nv_rdata))
    else $error("read data not loaded");
  chk_erase_only: assert property (@(posedge mclk) disable iff (!nrst)
    go && mode_r == NVAC_MODE_ERASE |=> nv_erase)
    else $error("erase not issued");
  chk_addr_upper: assert property (@(posedge mclk) disable iff (!nrst)
    io_rdata[7:1] == 7'h00 || $past(io_addr) != NVAC_REG_ADDR_UPPER
    || !$past(io_rd))
    else $error("upper address reserved bits nonzero");
  cov_read: cover property (@(posedge mclk) rd_go);
  cov_atomic: cover property (@(posedge mclk)
    go && mode_r == NVAC_MODE_ATOMIC);
  cov_write_only: cover property (@(posedge mclk)
    done && mode_r == NVAC_MODE_WRITE);
  cov_erase_only: cover property (@(posedge mclk)
    go && mode_r == NVAC_MODE_ERASE);
endmodule : nvac_ctrl

// [nvac_nv_model.sv]
`timescale 1ns/100ps
module nvac_nv_model (
  input wire logic mclk,
  input wire logic [8:0] nv_index,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_erase,
  input wire logic nv_write,
  output logic [7:0] nv_rdata
);
  logic [7:0] mem_r [512];
  initial for (int i = 0; i < 512; i++) mem_r[i] = 8'h5a;
  // write only clears bits, so an unerased byte is lost
  always @(posedge mclk) begin
    if (nv_erase) mem_r[nv_index] <= 8'hff;
    else if (nv_write) begin
      mem_r[nv_index] <= mem_r[nv_index] & nv_wdata;
    end
  end
  assign nv_rdata = mem_r[nv_index];
endmodule : nvac_nv_model

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import nvac_pkg::*;
  logic mclk, nrst, osc_tick, io_wr, io_rd, cpu_stall, ready_event;
  logic nv_erase, nv_write;
  logic [1:0] io_addr;
  logic [7:0] io_wdata, io_rdata, nv_wdata, nv_rdata, rv;
  logic [8:0] nv_index;
  int n_mismatch, n_tests;
  nvac_ctrl #(.ATOMIC_TICKS(20), .SPLIT_TICKS(5)) uut (.mclk(mclk),
    .nrst(nrst), .osc_tick(osc_tick), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall), .ready_event(ready_event), .nv_index(nv_index),
    .nv_wdata(nv_wdata), .nv_erase(nv_erase), .nv_write(nv_write),
    .nv_rdata(nv_rdata));
  nvac_nv_model model (.mclk(mclk), .nv_index(nv_index),
    .nv_wdata(nv_wdata), .nv_erase(nv_erase), .nv_write(nv_write),
    .nv_rdata(nv_rdata));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) osc_tick <= ~osc_tick;
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    @(negedge mclk);
    io_wr = 0;
  endtask : wr
  task automatic rd(logic [1:0] a);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1;
    @(negedge mclk);
    io_rd = 0;
    rv = io_rdata;
  endtask : rd
  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(NVAC_REG_CONTROL);
      if (rv[1] === 1'b0) return;
    end
    chk("busy timeout", 8'h01, 8'h00);
    complete_run();
  endtask : wait_idle
  task automatic stall_count(logic [7:0] e);
    int n;
    n = 0;
    repeat (8) begin
      if (cpu_stall === 1'b1) n++;
      @(negedge mclk);
    end
    chk("stall cycles", n[7:0], e);
  endtask : stall_count
  task automatic set_addr(logic [8:0] a);
    wr(NVAC_REG_ADDR_LOWER, a[7:0]);
    wr(NVAC_REG_ADDR_UPPER, {7'h00, a[8]});
  endtask : set_addr
  task automatic prog(logic [1:0] m, logic [8:0] a, logic [7:0] d);
    set_addr(a);
    wr(NVAC_REG_BUFFER, d);
    wr(NVAC_REG_CONTROL, {2'b00, m, 4'hc});
    wr(NVAC_REG_CONTROL, {2'b00, m, 4'ha});
    stall_count(8'h02);
  endtask : prog
  task automatic readback(logic [8:0] a, logic [7:0] e);
    set_addr(a);
    wr(NVAC_REG_CONTROL, 8'h01);
    stall_count(8'h04);
    rd(NVAC_REG_BUFFER);
    chk("array byte", rv, e);
  endtask : readback
  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(NVAC_REG_BUFFER);
    chk("buffer reset", rv, NVAC_BUFFER_RST);
    rd(NVAC_REG_CONTROL);
    chk("control reset", rv & 8'h3c, 8'h00);
    set_addr(9'h1ff);
    rd(NVAC_REG_ADDR_UPPER);
    chk("upper index", rv, 8'h01);
    rd(NVAC_REG_ADDR_LOWER);
    chk("lower index", rv, 8'hff);
  endtask : t_regs
  task automatic t_atomic;
    prog(NVAC_MODE_ATOMIC, 9'h1a5, 8'h3c);
    chk("ready busy", {7'h00, ready_event}, 8'h00);
    rd(NVAC_REG_CONTROL);
    chk("start held", rv & 8'h02, 8'h02);
    wr(NVAC_REG_CONTROL, 8'h29);
    wr(NVAC_REG_ADDR_LOWER, 8'h00);
    rd(NVAC_REG_CONTROL);
    chk("mode locked", rv & 8'h30, 8'h00);
    rd(NVAC_REG_BUFFER);
    chk("read blocked", rv, 8'h3c);
    wait_idle();
    chk("ready idle", {7'h00, ready_event}, 8'h01);
    wr(NVAC_REG_BUFFER, 8'h00);
    wr(NVAC_REG_CONTROL, 8'h01);
    stall_count(8'h04);
    rd(NVAC_REG_BUFFER);
    chk("atomic byte", rv, 8'h3c);
  endtask : t_atomic
  task automatic t_split;
    prog(NVAC_MODE_ERASE, 9'h00f, 8'h00);
    wait_idle();
    readback(9'h00f, 8'hff);
    prog(NVAC_MODE_WRITE, 9'h00f, 8'h96);
    wait_idle();
    readback(9'h00f, 8'h96);
  endtask : t_split
  task automatic t_refused;
    set_addr(9'h040);
    wr(NVAC_REG_BUFFER, 8'h11);
    wr(NVAC_REG_CONTROL, 8'h02);
    rd(NVAC_REG_CONTROL);
    chk("start unarmed", rv & 8'h02, 8'h00);
    wr(NVAC_REG_CONTROL, 8'h04);
    repeat (6) @(negedge mclk);
    wr(NVAC_REG_CONTROL, 8'h02);
    rd(NVAC_REG_CONTROL);
    chk("arm expired", rv & 8'h06, 8'h00);
    wr(NVAC_REG_CONTROL, {2'b00, NVAC_MODE_RSVD, 4'h4});
    wr(NVAC_REG_CONTROL, {2'b00, NVAC_MODE_RSVD, 4'h2});
    rd(NVAC_REG_CONTROL);
    chk("reserved mode", rv & 8'h02, 8'h00);
    readback(9'h040, 8'h5a);
  endtask : t_refused
  task automatic t_reset_busy;
    prog(NVAC_MODE_ATOMIC, 9'h100, 8'h77);
    nrst = 0;
    repeat (2) @(negedge mclk);
    nrst = 1;
    wait_idle();
    readback(9'h100, 8'h77);
  endtask : t_reset_busy
  ////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 0;
    osc_tick = 0;
    io_wr = 0;
    io_rd = 0;
    io_addr = 2'h0;
    io_wdata = 8'h00;
    n_mismatch = 0;
    n_tests = 0;
    repeat (16) @(negedge mclk);
    nrst = 1;
    t_regs();
    t_atomic();
    t_split();
    t_refused();
    t_reset_busy();
    complete_run();
  end
endmodule : tb_top
